/* File: core/dmp_pkg.sv */
// constants, types and shared helpers for the multi-port memory controller user ports
// How it works
// RL1: six-bit port enable parameter turns each of six 32-bit ports on; bit 0 is port 0.
// RL2: byte address maps to bank, row, column as bank-row-column or row-bank-column by parameter.
// RL3: arbitration table has 12 time slots, or 10 when exactly five ports are active.
// RL4: each slot holds six octal digits of port numbers, leftmost is most favoured.
// RL5: training patterns are written only at the configured row, bank and column base.
// RL6: calibrated mode centres the strobe and keeps tracking drift; otherwise a fixed offset.
// RL7: fixed strobe offset is a quarter, half, three quarters or a full bit period.
// RL8: calibration-done rises after all start-up phases; user waits for it before commands.
// RL9: the clock source supplies two alternate-cycle I/O strobes for double-rate transfers.
// RL10: main clock runs at twice memory clock, with an inverted copy from same source.
// RL11: calibration clock comes from the same phase-locked source as the double-rate clock.
// RL12: user byte address is 30 bits and aligned to the port width.
// RL13: six-bit burst field 0 to 63 means 1 to 64 port-wide words.
// RL14: command queue samples on rising user command clock edges when push is high.
// RL15: command-queue empty is high whenever nothing waits, even if commands still execute.
// RL16: command-queue full is high when no space is left and blocks further pushes.
// RL17: command-queue pointer fault asserts on lost pointer sync and stays until reset.
// RL18: opcode bit 0 read, bit 1 auto precharge, bit 2 refresh which overrides others.
// RL19: seven-bit write fill level reports 0 to 64 words and lags the empty flag.
// RL20: write data input is 32, 64 or 128 bits wide per port configuration.
// RL21: write-queue empty is high whenever no valid word is stored.
// RL22: write queue user side is clocked by its own per-port write clock.
// RL23: a word loads on a write-clock rising edge only with push high and not full.
// RL24: one mask bit per byte is stored with the data; high mask suppresses the byte.
// RL25: write-queue full is high when no more words fit and blocks loading.
// RL26: arbiter steps slots cyclically, granting highest-priority enabled port with a pending command.
// RL27: reset clears queues, faults and arbiter state and restarts calibration with done low.
package dmp_pkg;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int NUM_PORTS    = 6;
	localparam int CQ_DEPTH     = 4;
	localparam int CQ_PTR_W     = 3;
	localparam int WQ_DEPTH     = 64;
	localparam int WQ_PTR_W     = 7;
	localparam int ADDR_W       = 30;
	localparam int BL_W         = 6;
	localparam int OP_W         = 3;
	localparam int ROW_W        = 15;
	localparam int BANK_W       = 3;
	localparam int COL_W        = 12;
	localparam int SLOT_MAX     = 12;
	localparam int SLOT_W       = 18;
	localparam int DIGIT_W      = 3;
	localparam int WQ_MAX_W     = 128;
	localparam int TAP_W        = 8;
	localparam int TAP_PER_BIT  = 64;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS      = 50;
	localparam int CAL_SETTLE_NS      = 1000;
	localparam int CAL_SETTLE_CYC     = (CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECAL_INTERVAL_US  = 2000;
	localparam int RECAL_INTERVAL_CYC = (RECAL_INTERVAL_US * 1000) / CLK_PERIOD_NS;

	// ****************************************************************
	// opcodes and fixed values
	// ****************************************************************
	localparam int            OP_RD_BIT  = 0;
	localparam int            OP_AP_BIT  = 1;
	localparam int            OP_REF_BIT = 2;
	localparam logic [OP_W-1:0] OP_WRITE = 3'h0;
	localparam logic [OP_W-1:0] OP_READ  = 3'h1;
	localparam logic [2:0]    TRAIN_PORT = 3'h7;
	localparam logic [5:0]    PORT_ENABLE_DEFAULT = 6'h0F;

	typedef enum logic {ORDER_BANK_ROW_COL, ORDER_ROW_BANK_COL} dmp_order_e;
	typedef enum logic {ALIGN_CALIBRATED, ALIGN_FIXED} dmp_align_e;
	typedef enum logic [1:0] {OFFSET_QUARTER, OFFSET_HALF, OFFSET_THREE_QUARTER, OFFSET_FULL} dmp_offset_e;
	typedef enum logic [2:0] {CAL_SETTLE, CAL_TRAIN_WR, CAL_TRAIN_RD, CAL_CENTER, CAL_DONE} dmp_cal_e;

	typedef logic [SLOT_MAX-1:0][SLOT_W-1:0] dmp_slot_table_t;

	typedef struct packed {
		logic [OP_W-1:0]   opcode;
		logic [BL_W-1:0]   bl;
		logic [ADDR_W-1:0] addr;
	} dmp_cmd_s;

	typedef struct packed {
		logic     push;
		dmp_cmd_s cmd;
	} dmp_cmd_in_s;

	typedef struct packed {
		logic                  push;
		logic [WQ_MAX_W/8-1:0] mask;
		logic [WQ_MAX_W-1:0]   data;
	} dmp_wq_in_s;

	typedef struct packed {
		logic [2:0]        port;
		logic [OP_W-1:0]   opcode;
		logic [BL_W-1:0]   bl;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  col;
	} dmp_mem_cmd_s;

	// slot s favours port s mod 6 first, then the following ports in rising order, wrapping from 5 back to 0
	function automatic dmp_slot_table_t dmp_default_slots();
		dmp_slot_table_t t;
		t = '0;
		for (int s = 0; s < SLOT_MAX; s++)
			for (int k = 0; k < NUM_PORTS; k++)
				t[s][SLOT_W-1-DIGIT_W*k -: DIGIT_W] = DIGIT_W'((s + k) % NUM_PORTS);
		return t;
	endfunction

endpackage

/* File: core/dmp_user_ports.sv */
// user-side command queues, write queue, slot arbiter and calibration sequencer
`timescale 1ns/1ps
module dmp_user_ports #(
	parameter logic [5:0]      PORT_ENABLE            = dmp_pkg::PORT_ENABLE_DEFAULT,
	parameter dmp_pkg::dmp_order_e ADDR_ORDER         = dmp_pkg::ORDER_BANK_ROW_COL,
	parameter int              ARB_SLOT_TOTAL         = 12,
	parameter dmp_pkg::dmp_slot_table_t ARB_SLOT_PRIORITY_LIST = dmp_pkg::dmp_default_slots(),
	parameter logic [14:0]     TRAIN_ROW_BASE         = 15'h0000,
	parameter logic [2:0]      TRAIN_BANK_BASE        = 3'h0,
	parameter logic [11:0]     TRAIN_COL_BASE         = 12'h000,
	parameter dmp_pkg::dmp_align_e  STROBE_ALIGN_SELECT = dmp_pkg::ALIGN_CALIBRATED,
	parameter dmp_pkg::dmp_offset_e FIXED_STROBE_OFFSET = dmp_pkg::OFFSET_HALF,
	parameter int              WQ_WIDTH               = 32,
	parameter int              COL_BITS               = 10,
	parameter int              RECAL_INTERVAL_CYC     = dmp_pkg::RECAL_INTERVAL_CYC
) (
	// clock and reset
	input  wire logic                         i_clk,
	input  wire logic                         i_rst_n,
	// command queues, one lane per port
	input  wire logic [5:0]                   i_cq_user_clock,
	input  wire logic [5:0]                   i_cq_push,
	input  wire logic [5:0][2:0]              i_cq_opcode,
	input  wire logic [5:0][5:0]              i_cq_burst_words,
	input  wire logic [5:0][29:0]             i_cq_byte_address,
	output      logic [5:0]                   o_cq_is_empty,
	output      logic [5:0]                   o_cq_is_full,
	output      logic [5:0]                   o_cq_pointer_fault,
	// write queue of port 0
	input  wire logic                         i_wq_user_clock,
	input  wire logic                         i_wq_push,
	input  wire logic [WQ_WIDTH-1:0]          i_wq_word_in,
	input  wire logic [WQ_WIDTH/8-1:0]        i_wq_byte_mask,
	output      logic                         o_wq_is_empty,
	output      logic                         o_wq_is_full,
	output      logic [6:0]                   o_wq_fill_level,
	output      logic                         o_wq_pointer_fault,
	output      logic                         o_wq_underrun,
	// memory side
	output      logic                         o_mem_cmd_valid,
	output      dmp_pkg::dmp_mem_cmd_s        o_mem_cmd,
	output      logic                         o_mem_word_valid,
	output      logic [WQ_WIDTH-1:0]          o_mem_word,
	output      logic [WQ_WIDTH/8-1:0]        o_mem_mask,
	// calibration
	input  wire logic                         i_vt_step_up,
	input  wire logic                         i_vt_step_down,
	output      logic [7:0]                   o_strobe_tap,
	output      logic                         o_calib_done
);
	import dmp_pkg::*;

	// ****************************************************************
	// parameter checks
	// ****************************************************************
	localparam int ACTIVE_PORTS = $countones(PORT_ENABLE);
	localparam int WQ_SHIFT     = $clog2(WQ_WIDTH / 8);
	localparam logic [TAP_W-1:0] FIXED_TAP = TAP_W'((int'(FIXED_STROBE_OFFSET) + 1) * TAP_PER_BIT / 4); // RL7
	localparam logic [3:0] LAST_SLOT = 4'(ARB_SLOT_TOTAL - 1);

	generate
		if (WQ_WIDTH != 32 && WQ_WIDTH != 64 && WQ_WIDTH != 128) // RL20
			$error("write word width must be 32, 64 or 128");
		if (ARB_SLOT_TOTAL != ((ACTIVE_PORTS == 5) ? 10 : 12)) // RL3
			$error("slot count must be 10 with five ports, else 12");
		if (COL_BITS < 1 || COL_BITS > COL_W || RECAL_INTERVAL_CYC < 2)
			$error("column width or recalibration interval out of range");
	endgenerate

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [5:0]                         cclk_s1, cclk_s2, cclk_s3;
		dmp_cmd_in_s [5:0]                  cin_s1, cin_s2, cin_s3;
		logic                               wclk_s1, wclk_s2, wclk_s3;
		dmp_wq_in_s                         win_s1, win_s2, win_s3;
		dmp_cmd_s [5:0][CQ_DEPTH-1:0]       cq;
		logic [5:0][CQ_PTR_W-1:0]           cwp, crp;
		logic [5:0]                         cfault;
		logic [WQ_PTR_W-1:0]                wwp, wrp, wlevel;
		logic                               wfault, wunder;
		logic [3:0]                         slot;
		logic [BL_W-1:0]                    busy;
		logic                               wr_drain;
		logic                               mem_valid;
		dmp_mem_cmd_s                       mem_cmd;
		logic                               word_valid;
		logic [WQ_MAX_W/8-1:0]              mask;
		logic [WQ_MAX_W-1:0]                word;
		dmp_cal_e                           cal;
		logic [31:0]                        cal_cnt;
		logic [TAP_W-1:0]                   tap;
		logic                               cal_done;
	} dmp_state_s;

	dmp_state_s                          st_reg;
	dmp_state_s                          st_next;
	logic [WQ_MAX_W/8+WQ_MAX_W-1:0]      wq_mem [WQ_DEPTH];
	logic                                wq_we;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// first enabled port with a waiting command, in the slot's digit order
	function automatic logic [3:0] pick_port(input logic [SLOT_W-1:0] list, input logic [5:0] ready);
		logic [2:0] d;
		pick_port = 4'h0;
		// the leftmost digit is tried last so that it wins
		for (int k = 0; k < NUM_PORTS; k++)
		begin
			d = list[DIGIT_W*k +: DIGIT_W];
			if (d < 3'h6 && ready[d])
				pick_port = {1'b1, d}; // RL4 RL26
		end
	endfunction

	function automatic dmp_mem_cmd_s map_cmd(input logic [2:0] port, input dmp_cmd_s c);
		logic [31:0] wa;
		map_cmd.port   = port;
		map_cmd.opcode = c.opcode;
		map_cmd.bl     = c.bl;
		// low bits below the port word are dropped
		wa = (port == 3'h0) ? 32'({c.addr} >> WQ_SHIFT) : 32'({c.addr} >> 2);
		map_cmd.col = COL_W'(wa & ((32'h1 << COL_BITS) - 32'h1));
		if (ADDR_ORDER == ORDER_BANK_ROW_COL)
		begin
			map_cmd.row  = wa[COL_BITS +: ROW_W]; // RL2
			map_cmd.bank = wa[COL_BITS + ROW_W +: BANK_W];
		end
		else
		begin
			map_cmd.bank = wa[COL_BITS +: BANK_W]; // RL2
			map_cmd.row  = wa[COL_BITS + BANK_W +: ROW_W];
		end
	endfunction

	function automatic dmp_mem_cmd_s train_cmd(input logic [OP_W-1:0] op);
		train_cmd = '{port: TRAIN_PORT, opcode: op, bl: '0, bank: TRAIN_BANK_BASE,
			row: TRAIN_ROW_BASE, col: TRAIN_COL_BASE}; // RL5
	endfunction

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb
	begin
		logic [5:0]             c_edge;
		logic [5:0]             ready;
		logic [CQ_PTR_W-1:0]    c_used;
		logic [WQ_PTR_W-1:0]    w_used;
		logic                   w_edge;
		logic                   idle;
		logic                   claim;
		logic                   pop_word;
		logic [3:0]             pick;
		dmp_cmd_s               head;
		c_edge   = st_reg.cclk_s2 & ~st_reg.cclk_s3;
		w_edge   = st_reg.wclk_s2 & ~st_reg.wclk_s3;
		idle     = (st_reg.busy == '0);
		claim    = 1'b0;
		pop_word = 1'b0;
		pick     = 4'h0;
		head     = '0;
		ready    = '0;
		c_used   = '0;
		w_used   = st_reg.wwp - st_reg.wrp;
		wq_we    = 1'b0;
		st_next  = st_reg;

		// two-stage synchronisers; a third stage keeps the value from before each edge
		st_next.cclk_s1 = i_cq_user_clock;
		st_next.cclk_s2 = st_reg.cclk_s1;
		st_next.cclk_s3 = st_reg.cclk_s2;
		for (int p = 0; p < NUM_PORTS; p++)
			st_next.cin_s1[p] = '{push: i_cq_push[p], cmd: '{opcode: i_cq_opcode[p],
				bl: i_cq_burst_words[p], addr: i_cq_byte_address[p]}};
		st_next.cin_s2  = st_reg.cin_s1;
		st_next.cin_s3  = st_reg.cin_s2;
		st_next.wclk_s1 = i_wq_user_clock;
		st_next.wclk_s2 = st_reg.wclk_s1;
		st_next.wclk_s3 = st_reg.wclk_s2;
		st_next.win_s1  = '{push: i_wq_push, mask: (WQ_MAX_W/8)'(i_wq_byte_mask), data: WQ_MAX_W'(i_wq_word_in)};
		st_next.win_s2  = st_reg.win_s1;
		st_next.win_s3  = st_reg.win_s2;

		st_next.mem_valid  = 1'b0;
		st_next.word_valid = 1'b0;

		// ****************************************************************
		// command queue pushes and fault watch
		// ****************************************************************
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			c_used   = st_reg.cwp[p] - st_reg.crp[p];
			ready[p] = PORT_ENABLE[p] && (c_used != '0); // RL1
			if (PORT_ENABLE[p] && c_edge[p] && st_reg.cin_s3[p].push && c_used < CQ_PTR_W'(CQ_DEPTH)) // RL14 RL16
			begin
				st_next.cq[p][st_reg.cwp[p][1:0]] = st_reg.cin_s3[p].cmd;
				st_next.cwp[p] = st_reg.cwp[p] + 1'b1;
			end
			if (c_used > CQ_PTR_W'(CQ_DEPTH))
				st_next.cfault[p] = 1'b1; // RL17
		end

		// ****************************************************************
		// write queue push
		// ****************************************************************
		if (w_edge && st_reg.win_s3.push && w_used < WQ_PTR_W'(WQ_DEPTH)) // RL22 RL23 RL25
		begin
			wq_we = 1'b1;
			st_next.wwp = st_reg.wwp + 1'b1;
		end
		if (w_used > WQ_PTR_W'(WQ_DEPTH))
			st_next.wfault = 1'b1;
		st_next.wlevel = w_used; // RL19

		// ****************************************************************
		// calibration sequencer
		// ****************************************************************
		unique case (st_reg.cal)
			CAL_SETTLE:
			begin
				st_next.cal_cnt = st_reg.cal_cnt + 32'h1;
				if (st_reg.cal_cnt == 32'(CAL_SETTLE_CYC - 1))
				begin
					st_next.cal_cnt = '0;
					if (STROBE_ALIGN_SELECT == ALIGN_CALIBRATED)
						st_next.cal = CAL_TRAIN_WR;
					else
					begin
						st_next.tap      = FIXED_TAP; // RL6 RL7
						st_next.cal_done = 1'b1; // RL8
						st_next.cal      = CAL_DONE;
					end
				end
			end
			CAL_TRAIN_WR, CAL_TRAIN_RD:
				if (idle)
				begin
					claim             = 1'b1;
					st_next.mem_valid = 1'b1;
					st_next.mem_cmd   = train_cmd((st_reg.cal == CAL_TRAIN_WR) ? OP_WRITE : OP_READ); // RL5
					st_next.cal       = (st_reg.cal == CAL_TRAIN_WR) ? CAL_TRAIN_RD : CAL_CENTER;
					st_next.tap       = '0;
				end
			CAL_CENTER:
			begin
				// sweep the whole bit period, then park in the middle of the eye
				st_next.tap = st_reg.tap + 1'b1;
				if (st_reg.tap == TAP_W'(TAP_PER_BIT - 1))
				begin
					st_next.tap      = TAP_W'(TAP_PER_BIT / 2); // RL6
					st_next.cal_done = 1'b1; // RL8
					st_next.cal      = CAL_DONE;
				end
			end
			CAL_DONE:
				if (STROBE_ALIGN_SELECT == ALIGN_CALIBRATED)
				begin
					if (i_vt_step_up && !i_vt_step_down && st_reg.tap != TAP_W'(TAP_PER_BIT - 1))
						st_next.tap = st_reg.tap + 1'b1; // RL6
					else if (i_vt_step_down && !i_vt_step_up && st_reg.tap != '0)
						st_next.tap = st_reg.tap - 1'b1;
					if (st_reg.cal_cnt < 32'(RECAL_INTERVAL_CYC - 1))
						st_next.cal_cnt = st_reg.cal_cnt + 32'h1;
					else if (idle)
					begin
						claim             = 1'b1;
						st_next.cal_cnt   = '0;
						st_next.mem_valid = 1'b1;
						st_next.mem_cmd   = train_cmd(OP_WRITE); // RL5
					end
				end
			default:
				st_next.cal = CAL_SETTLE;
		endcase

		// ****************************************************************
		// slot arbiter and command issue
		// ****************************************************************
		if (!idle)
		begin
			st_next.busy = st_reg.busy - 1'b1;
			pop_word     = st_reg.wr_drain;
			if (st_reg.busy == BL_W'(1))
				st_next.wr_drain = 1'b0;
		end
		else if (st_reg.cal_done && !claim)
		begin
			pick = pick_port(ARB_SLOT_PRIORITY_LIST[st_reg.slot], ready); // RL26
			st_next.slot = (st_reg.slot == LAST_SLOT) ? 4'h0 : st_reg.slot + 4'h1; // RL3
			if (pick[3])
			begin
				head = st_reg.cq[pick[2:0]][st_reg.crp[pick[2:0]][1:0]];
				st_next.crp[pick[2:0]] = st_reg.crp[pick[2:0]] + 1'b1; // RL15
				st_next.mem_valid = 1'b1;
				st_next.mem_cmd   = map_cmd(pick[2:0], head);
				if (head.opcode[OP_REF_BIT])
					st_next.busy = '0; // RL18
				else
				begin
					st_next.busy     = head.bl; // RL13
					st_next.wr_drain = (pick[2:0] == 3'h0) && !head.opcode[OP_RD_BIT] && head.bl != '0;
					pop_word         = (pick[2:0] == 3'h0) && !head.opcode[OP_RD_BIT];
				end
			end
		end

		// one word per cycle of a port-0 write; an empty queue repeats the last word
		if (pop_word)
		begin
			st_next.word_valid = 1'b1;
			if (w_used != '0)
			begin
				{st_next.mask, st_next.word} = wq_mem[st_reg.wrp[5:0]]; // RL24
				st_next.wrp = st_reg.wrp + 1'b1;
			end
			else
				st_next.wunder = 1'b1;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			st_reg <= '0; // RL27
		else
			st_reg <= st_next;
	end

	always_ff @(posedge i_clk)
	begin
		if (wq_we)
			wq_mem[st_reg.wwp[5:0]] <= {st_reg.win_s3.mask, st_reg.win_s3.data}; // RL24
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	generate
		for (genvar p = 0; p < NUM_PORTS; p++)
		begin : g_cq_flags
			assign o_cq_is_empty[p] = (st_reg.cwp[p] == st_reg.crp[p]); // RL15
			assign o_cq_is_full[p]  = (CQ_PTR_W'(st_reg.cwp[p] - st_reg.crp[p]) >= CQ_PTR_W'(CQ_DEPTH)); // RL16
		end
	endgenerate

	assign o_cq_pointer_fault = st_reg.cfault;
	assign o_wq_is_empty      = (st_reg.wwp == st_reg.wrp); // RL21
	assign o_wq_is_full       = (WQ_PTR_W'(st_reg.wwp - st_reg.wrp) >= WQ_PTR_W'(WQ_DEPTH));
	assign o_wq_fill_level    = st_reg.wlevel;
	assign o_wq_pointer_fault = st_reg.wfault;
	assign o_wq_underrun      = st_reg.wunder;
	assign o_mem_cmd_valid    = st_reg.mem_valid;
	assign o_mem_cmd          = st_reg.mem_cmd;
	assign o_mem_word_valid   = st_reg.word_valid;
	assign o_mem_word         = st_reg.word[WQ_WIDTH-1:0];
	assign o_mem_mask         = st_reg.mask[WQ_WIDTH/8-1:0];
	assign o_strobe_tap       = st_reg.tap;
	assign o_calib_done       = st_reg.cal_done;

	// ****************************************************************
	// assertions
	// ****************************************************************
	a_user_after_cal: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL8
		o_mem_cmd_valid && !o_calib_done |-> o_mem_cmd.port == TRAIN_PORT)
		else $error("user command issued before calibration finished");

	a_train_addr_only: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL5
		o_mem_cmd_valid && o_mem_cmd.port == TRAIN_PORT |->
		o_mem_cmd.row == TRAIN_ROW_BASE && o_mem_cmd.bank == TRAIN_BANK_BASE && o_mem_cmd.col == TRAIN_COL_BASE)
		else $error("training pattern outside reserved area");

	a_grant_enabled: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL1
		o_mem_cmd_valid && o_mem_cmd.port != TRAIN_PORT |-> PORT_ENABLE[o_mem_cmd.port])
		else $error("command granted to disabled port");

	a_slot_wraps: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL3
		st_reg.slot == LAST_SLOT && st_next.slot != LAST_SLOT |=> st_reg.slot == 4'h0)
		else $error("slot index passed table end");

	a_full_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL16
		o_cq_is_full[0] |=> st_reg.cwp[0] == $past(st_reg.cwp[0]))
		else $error("command pushed into full queue");

	a_fault_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL17
		o_cq_pointer_fault[0] |=> o_cq_pointer_fault[0] [*3])
		else $error("pointer fault cleared without reset");

	a_wq_full_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL25
		o_wq_is_full |=> st_reg.wwp == $past(st_reg.wwp))
		else $error("word loaded into full write queue");

	a_level_range: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL19
		(o_wq_fill_level <= 7'h40) and (o_wq_is_empty && $stable(st_reg.wrp) && $stable(st_reg.wwp)
		|=> o_wq_fill_level == 7'h00))
		else $error("fill level out of range or not tracking empty");

	a_refresh_single: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL18
		o_mem_cmd_valid && o_mem_cmd.opcode[OP_REF_BIT] |-> st_reg.busy == '0 && !o_mem_word_valid)
		else $error("refresh occupied data cycles");

	a_fixed_tap: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RL7
		STROBE_ALIGN_SELECT == ALIGN_FIXED && o_calib_done |-> o_strobe_tap == FIXED_TAP)
		else $error("fixed strobe offset wrong");

	a_reset_restart: assert property (@(posedge i_clk) // RL27
		!i_rst_n |=> !o_calib_done && o_cq_is_empty == 6'h3F && !o_mem_cmd_valid)
		else $error("reset did not restart block");

endmodule

/* File: testbench/dmp_user_model.sv */
// user logic model: framed command and write clocks of 400 ns
`timescale 1ns/1ps
module dmp_user_model (
	input  wire logic	i_clk,
	output logic [5:0]	o_cclk,
	output logic [5:0]	o_cpush,
	output logic [5:0][2:0]	o_op,
	output logic [5:0][5:0]	o_bl,
	output logic [5:0][29:0]	o_addr,
	output logic	o_wclk,
	output logic	o_wpush,
	output logic [31:0]	o_wdata,
	output logic [3:0]	o_wmask
);
	initial {o_cclk, o_cpush, o_op, o_bl, o_addr, o_wclk, o_wpush, o_wdata, o_wmask} = '0;
	// ****************************************************************
	// clocks idle low between frames; released opcode, address and data are inverted
	// ****************************************************************
	task automatic cmd(input int p, input logic [2:0] op, input logic [5:0] bl);
		@(posedge i_clk);
		o_cpush[p] <= 1'b1;
		o_op[p] <= op;
		o_bl[p] <= bl;
		o_addr[p] <= 30'($urandom) & ~30'h3;
		repeat (3) @(posedge i_clk);
		o_cclk[p] <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_cclk[p] <= 1'b0;
		o_cpush[p] <= 1'b0;
		o_op[p] <= ~op;
		o_addr[p] <= ~o_addr[p];
	endtask
	task automatic wr(input logic [31:0] d, input logic [3:0] m);
		@(posedge i_clk);
		o_wpush <= 1'b1;
		o_wdata <= d;
		o_wmask <= m;
		repeat (3) @(posedge i_clk);
		o_wclk <= 1'b1;
		repeat (4) @(posedge i_clk);
		o_wclk <= 1'b0;
		o_wpush <= 1'b0;
		o_wdata <= ~d;
	endtask
endmodule

/* File: testbench/test_dmp_user_ports.sv */
// self-checking bench of the user-port block
`timescale 1ns/1ps
module test_dmp_user_ports;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_vt_step_up = 1'b0;
	logic i_vt_step_down = 1'b0;
	logic [5:0] cclk, cpush, o_cq_is_empty, o_cq_is_full, o_cq_pointer_fault;
	logic [5:0][2:0] op;
	logic [5:0][5:0] bl;
	logic [5:0][29:0] addr;
	logic wclk, wpush, o_wq_is_empty, o_wq_is_full, o_wq_pointer_fault, o_wq_underrun;
	logic o_mem_cmd_valid, o_mem_word_valid, o_calib_done;
	logic [31:0] wdata, o_mem_word;
	logic [3:0] wmask, o_mem_mask;
	logic [6:0] o_wq_fill_level;
	logic [7:0] o_strobe_tap;
	logic [8:0] c0;
	dmp_pkg::dmp_mem_cmd_s o_mem_cmd;
	logic [35:0] exp_q[$], seen_q[$];
	int num_errors = 0, checks = 0, grants = 0;
	dmp_user_model model (.i_clk, .o_cclk(cclk), .o_cpush(cpush), .o_op(op), .o_bl(bl), .o_addr(addr),
		.o_wclk(wclk), .o_wpush(wpush), .o_wdata(wdata), .o_wmask(wmask));
	dmp_user_ports #(.RECAL_INTERVAL_CYC(50)) uut (.i_clk, .i_rst_n, .i_cq_user_clock(cclk), .i_cq_push(cpush),
		.i_cq_opcode(op), .i_cq_burst_words(bl), .i_cq_byte_address(addr), .o_cq_is_empty, .o_cq_is_full,
		.o_cq_pointer_fault, .i_wq_user_clock(wclk), .i_wq_push(wpush), .i_wq_word_in(wdata),
		.i_wq_byte_mask(wmask), .o_wq_is_empty, .o_wq_is_full, .o_wq_fill_level, .o_wq_pointer_fault,
		.o_wq_underrun, .o_mem_cmd_valid, .o_mem_cmd, .o_mem_word_valid, .o_mem_word, .o_mem_mask,
		.i_vt_step_up, .i_vt_step_down, .o_strobe_tap, .o_calib_done);
	initial forever #25 i_clk = ~i_clk;
	always @(negedge i_clk)
	begin
		if (o_mem_cmd_valid && o_mem_cmd.port == 3'h1) grants++;
		if (o_mem_cmd_valid && o_mem_cmd.port == 3'h0) c0 = {o_mem_cmd.opcode, o_mem_cmd.bl};
		if (o_mem_word_valid && o_mem_cmd.port == 3'h0) seen_q.push_back({o_mem_mask, o_mem_word});
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] centre_tap(input int steps);
		return 8'(dmp_pkg::TAP_PER_BIT / 2 + steps);
	endfunction
	task automatic test_done();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		logic [35:0] w;
		void'($urandom(63));
		repeat (12) @(negedge i_clk);
		check({o_cq_is_empty, o_cq_is_full, o_cq_pointer_fault, o_wq_is_empty, o_calib_done, o_strobe_tap},
			{6'h3F, 12'h000, 2'h2, 8'h00});
		@(posedge i_clk) i_rst_n <= 1'b1;
		for (int i = 0; i < 300 && o_calib_done !== 1'b1; i++) @(negedge i_clk);
		check(o_calib_done, 1'b1);
		if (o_calib_done !== 1'b1) test_done();
		check(o_strobe_tap, centre_tap(0));
		@(posedge i_clk) i_vt_step_up <= 1'b1;
		@(posedge i_clk) i_vt_step_up <= 1'b0;
		repeat (2) @(negedge i_clk);
		check(o_strobe_tap, centre_tap(1));
		@(posedge i_clk) i_vt_step_down <= 1'b1;
		@(posedge i_clk) i_vt_step_down <= 1'b0;
		repeat (2) @(negedge i_clk);
		check(o_strobe_tap, centre_tap(0));
		$display("test calibration over");
		for (int i = 0; i < 4; i++)
		begin
			w = {4'($urandom), 32'($urandom)};
			exp_q.push_back(w);
			model.wr(w[31:0], w[35:32]);
		end
		repeat (6) @(negedge i_clk);
		check(o_wq_fill_level, 7'h04);
		model.cmd(0, 3'h0, 6'h03);
		repeat (40) @(negedge i_clk);
		check(c0, {3'h0, 6'h03});
		foreach (exp_q[i]) check(seen_q[i], exp_q[i]);
		check({o_wq_is_empty, 7'(seen_q.size())}, {1'b1, 7'h04});
		model.cmd(0, 3'h4, 6'h05);
		repeat (4) @(negedge i_clk);
		check({c0, o_wq_underrun, 7'(seen_q.size())}, {3'h4, 6'h05, 1'b0, 7'h04});
		$display("test write burst over");
		model.cmd(4, 3'h4, 6'h00);
		repeat (8) @(negedge i_clk);
		check(o_cq_is_empty[4], 1'b1);
		for (int i = 0; i < 6; i++) model.cmd(1, {1'b0, 1'($urandom), 1'b1}, 6'h3F);
		repeat (4) @(negedge i_clk);
		check(o_cq_is_full[1], 1'b1);
		repeat (400) @(negedge i_clk);
		check({o_cq_is_empty[1], 8'(grants)}, {1'b1, 8'h05});
		check({o_cq_pointer_fault, o_wq_pointer_fault, o_wq_underrun}, 8'h00);
		$display("test command queue over");
		test_done();
	end
endmodule
